// ### core/tcm_pkg.sv
// constants, types and register map of the timer channel mode and output control block
// Contract
// - mode field picks function and count direction
// - start option gives interrupt and toggle at start, except in one-count and capture-one-count
// - one-count, option set: retrigger reloads, no interrupt
// - otherwise one-count triggers ignored; capture-one-count silent start
// - output disabled: software level drives pin
// - output enabled: timer drives bit 0 only, writes ignored
// - output level bit drives output pin
// - request flag set on event; mask blocks
// - channels 2 and 3 only on large variant
// - count clock from prescaler or input edges
package tcm_pkg;
   localparam int DW = 32;
   localparam int AW = 8;
   localparam int CW = 16;
   localparam int NCH = 4;
   localparam int NCH_SMALL = 2;
   localparam int NEV = 3;
   localparam int PW = 15;
   ////////////////////////////////////////////////////////////////////////////
   localparam logic [AW-1:0] OFS_MODE = 8'h00;
   localparam logic [AW-1:0] OFS_CTRL = 8'h04;
   localparam logic [AW-1:0] OFS_DATA = 8'h08;
   localparam logic [AW-1:0] OFS_COUNT = 8'h0C;
   localparam logic [AW-1:0] OFS_OUTEN = 8'h10;
   localparam logic [AW-1:0] OFS_OUTLVL = 8'h14;
   localparam logic [AW-1:0] OFS_MASK = 8'h18;
   localparam logic [AW-1:0] OFS_FLAG = 8'h1C;
   localparam logic [AW-1:0] OFS_STAT = 8'h20;
   localparam logic [AW-1:0] OFS_CLR = 8'h24;
   localparam logic [AW-1:0] OFS_EN = 8'h28;
   ////////////////////////////////////////////////////////////////////////////
   localparam int SOPT_BIT = 0;
   localparam int MODE_LSB = 1;
   localparam int START_BIT = 0;
   localparam int STOP_BIT = 1;
   localparam int PINTRIG_BIT = 2;
   localparam int RUN_BIT = 3;
   localparam int CCS_BIT = 4;
   localparam int PRESC_LSB = 8;
   localparam int FLAG_BIT = 6;
   localparam int EV_START = 0;
   localparam int EV_TERM = 1;
   localparam int EV_CAP = 2;
   localparam logic [7:0] MASK_RST = 8'hFF;
   localparam logic [7:0] FLAG_RST = 8'h00;
   localparam logic [CW-1:0] CNT_RST = 16'h0000;
   localparam logic [CW-1:0] CNT_ONE = 16'h0001;
   ////////////////////////////////////////////////////////////////////////////
   localparam logic [2:0] MD_INTERVAL = 3'h0;
   localparam logic [2:0] MD_CAPTURE = 3'h2;
   localparam logic [2:0] MD_EVENT = 3'h3;
   localparam logic [2:0] MD_ONECNT = 3'h4;
   localparam logic [2:0] MD_CAPONE = 3'h6;
   typedef enum logic [0:0] {TCM_IDLE = 1'b0, TCM_RUN = 1'b1} tcm_state_t;
endpackage

// ### core/tcm_presc.sv
// prescaler producing a count tick every 2^sel clocks
`timescale 1ns/100ps
module tcm_presc
   import tcm_pkg::*;
(
   input logic i_ref_clk,
   input logic i_resetn,
   input logic i_clk_en,
   input logic [3:0] i_sel,
   output logic o_tick
);
   typedef struct packed {
      logic [PW-1:0] cnt_q;
      logic tick_q;
   } tcm_presc_st_t;
   tcm_presc_st_t s, n;
   logic [PW-1:0] msk;

   always_comb begin
      n = s;
      msk = PW'((1 << i_sel) - 1);
      n.cnt_q = s.cnt_q + PW'(1);
      n.tick_q = ((s.cnt_q & msk) == msk);
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s <= '0;
      end else if (i_clk_en) begin
         s <= n;
      end
   end

   assign o_tick = s.tick_q;
endmodule

// ### core/tcm_edge.sv
// edge detector for the timer input pin
`timescale 1ns/100ps
module tcm_edge (
   input logic i_ref_clk,
   input logic i_resetn,
   input logic i_clk_en,
   input logic i_pin,
   output logic o_rise,
   output logic o_fall
);
   typedef struct packed {
      logic prev_q;
      logic rise_q;
      logic fall_q;
   } tcm_edge_st_t;
   tcm_edge_st_t s, n;

   always_comb begin
      n = s;
      n.prev_q = i_pin;
      n.rise_q = i_pin & ~s.prev_q;
      n.fall_q = ~i_pin & s.prev_q;
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s <= '0;
      end else if (i_clk_en) begin
         s <= n;
      end
   end

   assign o_rise = s.rise_q;
   assign o_fall = s.fall_q;
endmodule

// ### core/tcm_top.sv
// timer channel with mode, output control and request flag, Avalon-MM slave
`timescale 1ns/100ps
module tcm_top
   import tcm_pkg::*;
#(
   parameter bit LARGE_PKG = 1'b1
)(
   input logic i_ref_clk,
   input logic i_resetn,
   input logic i_clk_en,
   input logic [AW-1:0] i_address,
   input logic i_read,
   input logic i_write,
   input logic [DW-1:0] i_writedata,
   output logic [DW-1:0] o_readdata,
   output logic o_waitrequest,
   input logic i_timer_input_pin,
   output logic [NCH-1:0] o_timer_out,
   output logic o_chan_irq,
   output logic o_irq
);
   typedef struct packed {
      logic wait_q;
      logic [DW-1:0] rdata_q;
      tcm_state_t st_q;
      logic [2:0] mode_q;
      logic sopt_q;
      logic ccs_q;
      logic pintrig_q;
      logic [3:0] presc_q;
      logic [CW-1:0] data_q;
      logic [CW-1:0] cnt_q;
      logic [NCH-1:0] oe_q;
      logic [NCH-1:0] lvl_q;
      logic [7:0] mask_q;
      logic [7:0] flag_q;
      logic [NEV-1:0] stat_q;
      logic [NEV-1:0] en_q;
      logic irq_q;
      logic chan_irq_q;
   } tcm_st_t;
   tcm_st_t s, n;

   logic presc_tick, pin_rise, pin_fall;
   logic wr_acc, tick, start, stop_sw, start_sw, toggle, is_up, is_down, mode_ok, cap;
   logic [NEV-1:0] ev, clr;
   logic [NCH-1:0] ch_ok;
   logic [DW-1:0] rd;

   ////////////////////////////////////////////////////////////////////////////
   tcm_presc u_presc (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_clk_en(i_clk_en),
      .i_sel(s.presc_q),
      .o_tick(presc_tick)
   );

   tcm_edge u_edge (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_clk_en(i_clk_en),
      .i_pin(i_timer_input_pin),
      .o_rise(pin_rise),
      .o_fall(pin_fall)
   );

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic valid_mode(input logic [2:0] m);
      return (m == MD_INTERVAL) || (m == MD_CAPTURE) || (m == MD_EVENT) ||
         (m == MD_ONECNT) || (m == MD_CAPONE);
   endfunction

   function automatic logic up_mode(input logic [2:0] m);
      return (m == MD_CAPTURE) || (m == MD_CAPONE);
   endfunction

   // channels present on this package variant
   generate
      for (genvar c = 0; c < NCH; c++) begin : g_ch
         assign ch_ok[c] = (c < NCH_SMALL) || LARGE_PKG;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      rd = '0;
      case (i_address)
         OFS_MODE: begin
            rd[SOPT_BIT] = s.sopt_q;
            rd[MODE_LSB +: 3] = s.mode_q;
         end
         OFS_CTRL: begin
            rd[PINTRIG_BIT] = s.pintrig_q;
            rd[RUN_BIT] = (s.st_q == TCM_RUN);
            rd[CCS_BIT] = s.ccs_q;
            rd[PRESC_LSB +: 4] = s.presc_q;
         end
         OFS_DATA: rd = DW'(s.data_q);
         OFS_COUNT: rd = DW'(s.cnt_q);
         OFS_OUTEN: rd = DW'(s.oe_q);
         OFS_OUTLVL: rd = DW'(s.lvl_q);
         OFS_MASK: rd = DW'(s.mask_q);
         OFS_FLAG: rd = DW'(s.flag_q);
         OFS_STAT: rd = DW'(s.stat_q);
         OFS_EN: rd = DW'(s.en_q);
         default: rd = '0;
      endcase
   end

   always_comb begin
      n = s;
      n.wait_q = 1'b1;
      wr_acc = i_write & ~s.wait_q;
      start_sw = 1'b0;
      stop_sw = 1'b0;
      clr = '0;
      ev = '0;
      toggle = 1'b0;
      cap = 1'b0;
      if ((i_read | i_write) && s.wait_q) begin
         n.wait_q = 1'b0;
         n.rdata_q = rd;
      end
      if (wr_acc) begin
         case (i_address)
            OFS_MODE: begin
               n.sopt_q = i_writedata[SOPT_BIT];
               n.mode_q = i_writedata[MODE_LSB +: 3];
            end
            OFS_CTRL: begin
               start_sw = i_writedata[START_BIT];
               stop_sw = i_writedata[STOP_BIT];
               n.pintrig_q = i_writedata[PINTRIG_BIT];
               n.ccs_q = i_writedata[CCS_BIT];
               n.presc_q = i_writedata[PRESC_LSB +: 4];
            end
            OFS_DATA: n.data_q = i_writedata[CW-1:0];
            OFS_OUTEN: n.oe_q = i_writedata[NCH-1:0] & ch_ok;
            OFS_OUTLVL: begin
               for (int c = 0; c < NCH; c++) begin
                  if (!s.oe_q[c] && ch_ok[c]) begin
                     n.lvl_q[c] = i_writedata[c];
                  end
               end
            end
            OFS_MASK: n.mask_q = i_writedata[7:0];
            OFS_FLAG: n.flag_q = i_writedata[7:0];
            OFS_CLR: clr = i_writedata[NEV-1:0];
            OFS_EN: n.en_q = i_writedata[NEV-1:0];
            default: ;
         endcase
      end

      // timer engine
      mode_ok = valid_mode(s.mode_q);
      is_up = up_mode(s.mode_q);
      is_down = mode_ok && !is_up;
      tick = s.ccs_q ? pin_rise : presc_tick;
      if (s.mode_q == MD_CAPONE) begin
         start = start_sw | (s.pintrig_q & pin_rise);
      end else begin
         start = start_sw | (s.pintrig_q & pin_rise & ~(s.mode_q == MD_CAPTURE));
      end
      // idle waits for a start, run steps the count
      case (s.st_q)
         TCM_IDLE: begin
            if (start && mode_ok) begin
               n.st_q = TCM_RUN;
               n.cnt_q = is_up ? CNT_RST : s.data_q;
               if (s.sopt_q && (s.mode_q == MD_INTERVAL || s.mode_q == MD_CAPTURE ||
                  s.mode_q == MD_EVENT)) begin
                  ev[EV_START] = 1'b1;
                  toggle = 1'b1;
               end
            end
         end
         TCM_RUN: begin
            if (stop_sw || !mode_ok) begin
               n.st_q = TCM_IDLE;
            end else if (s.mode_q == MD_CAPTURE && pin_rise) begin
               cap = 1'b1;
               n.data_q = s.cnt_q;
               n.cnt_q = CNT_RST;
               ev[EV_CAP] = 1'b1;
            end else if (s.mode_q == MD_CAPONE && pin_fall) begin
               cap = 1'b1;
               n.data_q = s.cnt_q;
               n.st_q = TCM_IDLE;
               ev[EV_CAP] = 1'b1;
            end else if (start && s.mode_q == MD_ONECNT && s.sopt_q) begin
               n.cnt_q = s.data_q;
            end else if (start && s.mode_q != MD_ONECNT && s.mode_q != MD_CAPONE) begin
               n.cnt_q = is_up ? CNT_RST : s.data_q;
               if (s.sopt_q) begin
                  ev[EV_START] = 1'b1;
                  toggle = 1'b1;
               end
            end else if (tick && (!start || s.mode_q == MD_ONECNT || s.mode_q == MD_CAPONE)) begin
               // triggers in one-count without option and capture-one-count fall through here
               if (is_up) begin
                  n.cnt_q = s.cnt_q + CNT_ONE;
               end else if (s.cnt_q == CNT_RST) begin
                  ev[EV_TERM] = 1'b1;
                  toggle = 1'b1;
                  if (s.mode_q == MD_ONECNT) begin
                     n.st_q = TCM_IDLE;
                  end else begin
                     n.cnt_q = s.data_q;
                  end
               end else begin
                  n.cnt_q = s.cnt_q - CNT_ONE;
               end
            end
         end
         default: n.st_q = TCM_IDLE;
      endcase

      // only an enabled channel 0 follows the timer
      if (s.oe_q[0] && toggle) begin
         n.lvl_q[0] = ~s.lvl_q[0];
      end
      // hardware set wins over software write or clear
      n.flag_q[FLAG_BIT] = n.flag_q[FLAG_BIT] | (|ev);
      n.stat_q = (s.stat_q & ~clr) | ev;
      n.irq_q = |(n.stat_q & s.en_q);
      n.chan_irq_q = n.flag_q[FLAG_BIT] & ~n.mask_q[FLAG_BIT];
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s <= '0;
         s.wait_q <= 1'b1;
         s.st_q <= TCM_IDLE;
         s.mask_q <= MASK_RST;
         s.flag_q <= FLAG_RST;
         s.cnt_q <= CNT_RST;
      end else if (i_clk_en) begin
         s <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign o_readdata = s.rdata_q;
   assign o_waitrequest = s.wait_q;
   assign o_timer_out = s.lvl_q;
   assign o_chan_irq = s.chan_irq_q;
   assign o_irq = s.irq_q;

   ////////////////////////////////////////////////////////////////////////////
   property p_down_count;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_clk_en && s.st_q == TCM_RUN && is_down && tick && !start && !stop_sw && s.cnt_q != CNT_RST)
      |=> (s.cnt_q == $past(s.cnt_q) - CNT_ONE);
   endproperty
   a_down_count: assert property (p_down_count) else $error("down count step wrong");

   property p_start_irq;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_clk_en && s.st_q == TCM_IDLE && start && s.mode_q == MD_INTERVAL && s.sopt_q)
      |=> s.flag_q[FLAG_BIT] && s.stat_q[EV_START];
   endproperty
   a_start_irq: assert property (p_start_irq) else $error("no request at count start");

   property p_no_start_irq;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      ev[EV_START] |-> s.sopt_q && s.mode_q != MD_ONECNT && s.mode_q != MD_CAPONE;
   endproperty
   a_no_start_irq: assert property (p_no_start_irq) else $error("start request without option");

   property p_retrigger;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_clk_en && s.st_q == TCM_RUN && s.mode_q == MD_ONECNT && s.sopt_q && start && !stop_sw)
      |=> (s.cnt_q == $past(s.data_q)) && (s.stat_q == $past(s.stat_q & ~clr));
   endproperty
   a_retrigger: assert property (p_retrigger) else $error("retrigger not taken quietly");

   property p_ignore;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_clk_en && s.st_q == TCM_RUN && s.mode_q == MD_ONECNT && !s.sopt_q && start && !tick && !stop_sw)
      |=> s.cnt_q == $past(s.cnt_q);
   endproperty
   a_ignore: assert property (p_ignore) else $error("trigger not ignored");

   property p_sw_level;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_clk_en && wr_acc && i_address == OFS_OUTLVL && !s.oe_q[0])
      |=> o_timer_out[0] == $past(i_writedata[0]);
   endproperty
   a_sw_level: assert property (p_sw_level) else $error("software level not driven");

   property p_timer_level;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_clk_en && s.oe_q[0]) |=> o_timer_out[0] == ($past(s.lvl_q[0]) ^ $past(toggle));
   endproperty
   a_timer_level: assert property (p_timer_level) else $error("timer output altered");

   property p_reload;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_clk_en && s.st_q == TCM_RUN && s.mode_q == MD_INTERVAL && tick && !start && !stop_sw &&
         s.cnt_q == CNT_RST) |=> s.cnt_q == $past(s.data_q) && s.flag_q[FLAG_BIT];
   endproperty
   a_reload: assert property (p_reload) else $error("no reload at zero");

   property p_mask;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_clk_en && ev[EV_TERM]) |=> o_chan_irq == !s.mask_q[FLAG_BIT];
   endproperty
   a_mask: assert property (p_mask) else $error("request mask wrong");

   property p_ext_clock;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_clk_en && s.ccs_q && s.st_q == TCM_RUN && mode_ok && !pin_rise && !pin_fall && !start &&
         !stop_sw) |=> s.cnt_q == $past(s.cnt_q);
   endproperty
   a_ext_clock: assert property (p_ext_clock) else $error("count without input edge");

   property p_variant;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      !LARGE_PKG |-> s.oe_q[NCH-1:NCH_SMALL] == '0;
   endproperty
   a_variant: assert property (p_variant) else $error("absent channel enabled");

   property p_capture;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_clk_en && cap) |=> s.stat_q[EV_CAP] && s.data_q == $past(s.cnt_q);
   endproperty
   a_capture: assert property (p_capture) else $error("capture not taken");

   property p_flag_set;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_clk_en && |ev) |=> s.flag_q[FLAG_BIT];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("request flag not set");

   property p_quiet_start;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      (i_clk_en && s.st_q == TCM_IDLE && start && mode_ok && (!s.sopt_q || s.mode_q == MD_CAPONE) && !wr_acc)
      |=> o_timer_out[0] == $past(s.lvl_q[0]) && s.stat_q == $past(s.stat_q);
   endproperty
   a_quiet_start: assert property (p_quiet_start) else $error("start changed output or request");
endmodule

// ### test/tcm_pin_src.sv
// pulse source driving the timer input pin
`timescale 1ns/100ps
module tcm_pin_src (
   input logic i_ref_clk,
   input logic i_resetn,
   input logic i_go,
   input logic [7:0] i_count,
   output logic o_pin,
   output logic o_busy
);
   logic [7:0] left_q;
   logic [2:0] ph_q;
   // each pulse: four cycles high, four low; idle low
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         left_q <= 8'h00;
         ph_q <= 3'h0;
         o_pin <= 1'b0;
      end else if (i_go) begin
         left_q <= i_count;
         ph_q <= 3'h0;
      end else if (left_q != 8'h00) begin
         ph_q <= ph_q + 3'h1;
         o_pin <= ~ph_q[2];
         if (ph_q == 3'h7) begin
            left_q <= left_q - 8'h01;
         end
      end else begin
         o_pin <= 1'b0;
      end
   end
   assign o_busy = (left_q != 8'h00);
endmodule

// ### test/timer_channel_mode_output_ctrl_test.sv
// self-checking bench for the timer channel block
`timescale 1ns/100ps
module timer_channel_mode_output_ctrl_test;
   import tcm_pkg::*;
   typedef struct {logic wr; logic [AW-1:0] a; logic [DW-1:0] d;} tcm_row_t;
   logic i_ref_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic [AW-1:0] i_address = '0;
   logic i_read = 1'b0;
   logic i_write = 1'b0;
   logic [DW-1:0] i_writedata = '0;
   logic [DW-1:0] o_readdata;
   logic o_waitrequest;
   logic pin;
   logic [NCH-1:0] o_timer_out;
   logic o_chan_irq;
   logic o_irq;
   logic [7:0] n_pulse = 8'h00;
   logic go = 1'b0;
   logic src_busy;
   logic [DW-1:0] q;
   logic exp0 = 1'b0;
   int err_total = 0;
   int compares = 0;
   int n;
   logic [2:0] md [7] = '{MD_INTERVAL, MD_INTERVAL, MD_CAPTURE, MD_CAPTURE, MD_EVENT, MD_EVENT, MD_CAPONE};
   logic op [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   // reads carry expected data in d
   tcm_row_t rows [14] = '{
      '{1'b0, OFS_MODE, 32'h0}, '{1'b0, OFS_MASK, 32'h0000_00FF}, '{1'b0, OFS_FLAG, 32'h0},
      '{1'b0, OFS_OUTEN, 32'h0}, '{1'b0, OFS_OUTLVL, 32'h0}, '{1'b1, OFS_STAT, 32'h7},
      '{1'b0, OFS_STAT, 32'h0}, '{1'b1, 8'h3C, 32'h5}, '{1'b0, 8'h3C, 32'h0}, '{1'b0, OFS_CLR, 32'h0},
      '{1'b1, OFS_MODE, 32'hD}, '{1'b0, OFS_MODE, 32'hD},
      '{1'b1, OFS_OUTLVL, 32'hA}, '{1'b0, OFS_OUTLVL, 32'hA}};

   tcm_top #(.LARGE_PKG(1'b1)) dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_clk_en(1'b1),
      .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
      .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_timer_input_pin(pin),
      .o_timer_out(o_timer_out), .o_chan_irq(o_chan_irq), .o_irq(o_irq));
   tcm_pin_src src (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_go(go), .i_count(n_pulse),
      .o_pin(pin), .o_busy(src_busy));

   initial begin
      forever #4 i_ref_clk = ~i_ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic fail(input string m);
      err_total++;
      $display("CHECK FAILED t=%0t %s", $time, m);
   endtask
   task automatic chk(input logic [DW-1:0] g, input logic [DW-1:0] e, input string m);
      compares++;
      if (g !== e) fail(m);
   endtask
   task automatic close_out;
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // hold the request until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge i_ref_clk);
      i_address <= a;
      i_write <= wr;
      i_read <= !wr;
      i_writedata <= d;
      @(posedge i_ref_clk);
      while (o_waitrequest !== 1'b0) begin
         @(posedge i_ref_clk);
      end
      q = o_readdata;
      i_read <= 1'b0;
      i_write <= 1'b0;
   endtask
   task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e, input string m);
      bus(1'b0, a, 32'h0);
      chk(q, e, m);
   endtask
   task automatic settle(input int c);
      repeat (c) @(negedge i_ref_clk);
   endtask
   task automatic pulses(input logic [7:0] c);
      @(posedge i_ref_clk);
      n_pulse <= c;
      go <= 1'b1;
      @(posedge i_ref_clk);
      go <= 1'b0;
      settle(1);
      n = 0;
      while (src_busy === 1'b1 && n < 300) begin
         n++;
         settle(1);
      end
      settle(3);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge i_ref_clk);
      fail("watchdog expired");
      close_out;
   end

   initial begin
      repeat (2) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      foreach (rows[i]) begin
         bus(rows[i].wr, rows[i].a, rows[i].d);
         if (!rows[i].wr) chk(q, rows[i].d, "register table");
      end
      settle(1);
      chk(o_timer_out, 4'hA, "software pin levels");
      $display("end: register table");
      // start option across modes, channel 0 timer driven
      bus(1'b1, OFS_OUTEN, 32'h1);
      bus(1'b1, OFS_DATA, 32'h64);
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, OFS_CLR, 32'h7);
         bus(1'b1, OFS_FLAG, 32'h0);
         bus(1'b1, OFS_MODE, {28'h0, md[i], op[i]});
         bus(1'b1, OFS_CTRL, 32'h0000_0401);
         exp0 = exp0 ^ op[i];
         rd(OFS_STAT, op[i], "start request");
         rd(OFS_FLAG, {op[i], 6'h0}, "start flag");
         chk(o_timer_out[0], exp0, "start toggle");
         bus(1'b1, OFS_CTRL, 32'h0000_0402);
      end
      bus(1'b1, OFS_OUTLVL, {31'h0, ~exp0});
      settle(1);
      chk(o_timer_out, {3'h0, exp0}, "enabled bit ignores write");
      $display("end: start option");
      // zero reload with request, mask and level interrupt
      bus(1'b1, OFS_CLR, 32'h7);
      bus(1'b1, OFS_FLAG, 32'h0);
      bus(1'b1, OFS_MASK, 32'h0);
      bus(1'b1, OFS_EN, 32'h2);
      bus(1'b1, OFS_DATA, 32'h3);
      bus(1'b1, OFS_MODE, 32'h0);
      bus(1'b1, OFS_CTRL, 32'h1);
      n = 0;
      while (o_irq !== 1'b1 && n < 40) begin
         n++;
         settle(1);
      end
      chk(n < 40, 1'b1, "zero reached");
      chk(o_chan_irq, 1'b1, "unmasked request");
      bus(1'b1, OFS_CTRL, 32'h2);
      bus(1'b1, OFS_MASK, 32'h0000_00FF);
      settle(2);
      chk(o_chan_irq, 1'b0, "masked request");
      bus(1'b1, OFS_CLR, 32'h7);
      settle(2);
      chk(o_irq, 1'b0, "cleared interrupt");
      $display("end: reload and interrupt");
      // one-count retrigger with and without option
      bus(1'b1, OFS_DATA, 32'hC8);
      for (int k = 0; k < 2; k++) begin
         bus(1'b1, OFS_MODE, {28'h0, MD_ONECNT, k[0]});
         bus(1'b1, OFS_CTRL, 32'h1);
         repeat (100) @(posedge i_ref_clk);
         bus(1'b1, OFS_CLR, 32'h7);
         bus(1'b1, OFS_CTRL, 32'h1);
         bus(1'b0, OFS_COUNT, 32'h0);
         chk(q > 150, k[0], "retrigger reload");
         rd(OFS_STAT, 32'h0, "retrigger quiet");
         bus(1'b1, OFS_CTRL, 32'h2);
      end
      $display("end: one-count retrigger");
      // event counting from pin edges only
      bus(1'b1, OFS_MODE, {28'h0, MD_EVENT, 1'b0});
      bus(1'b1, OFS_DATA, 32'h5);
      bus(1'b1, OFS_CTRL, 32'h0000_0011);
      pulses(8'h02);
      rd(OFS_COUNT, 32'h3, "pin edges counted");
      bus(1'b1, OFS_CTRL, 32'h2);
      $display("end: event counter");
      // input pin capture, free running and pin started
      for (int k = 0; k < 2; k++) begin
         bus(1'b1, OFS_CLR, 32'h7);
         bus(1'b1, OFS_MODE, {28'h0, (k == 0) ? MD_CAPTURE : MD_CAPONE, 1'b0});
         bus(1'b1, OFS_CTRL, (k == 0) ? 32'h0000_0001 : 32'h0000_0004);
         pulses(8'h01);
         rd(OFS_STAT, 32'h4, "capture request");
         rd(OFS_CTRL, (k == 0) ? 32'h0000_0008 : 32'h0000_0004, "run after capture");
         bus(1'b1, OFS_CTRL, 32'h2);
      end
      $display("end: capture");
      // reset with the timer stopped, after clearing the mask
      bus(1'b1, OFS_MASK, 32'h0);
      @(posedge i_ref_clk);
      i_resetn <= 1'b0;
      settle(1);
      chk({o_timer_out, o_irq, o_chan_irq, o_waitrequest}, 7'h01, "outputs in reset");
      @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      rd(OFS_MASK, 32'h0000_00FF, "mask after reset");
      $display("end: reset");
      close_out;
   end
endmodule
